// ### src/ldgc_pkg.sv
// Package for the LED driver global configuration block
package ldgc_pkg;
  localparam int CMD_W = 5;
  localparam logic [4:0] CMD_LATCH = 5'h01;
  localparam logic [4:0] CMD_WRITE = 5'h04;
  localparam logic [4:0] CMD_READ = 5'h05;
  localparam logic [4:0] CMD_SOFT_RESET_CMD = 5'h0A;
  localparam logic [4:0] CMD_UNLOCK = 5'h0E;
  localparam int FRAME_W = 48;
  localparam logic [15:0] CFG1_RST = 16'h0060;
  localparam logic [15:0] CFG2_RST = 16'h0E00;
  localparam logic [15:0] CFG1_MASK = 16'h3FFF;
  localparam int GS_POS = 12;
  localparam int SP_POS = 10;
  localparam int SCAN_POS = 5;
  localparam int MULT_POS = 4;
  localparam int SHORT_POS = 11;
  localparam int CG_POS = 9;
  localparam int AG_POS = 6;
  localparam int STAG_POS = 3;
  localparam int STAG_UNIT_NS = 25;
  localparam int CLK_NS = 10;
  localparam int STAG_UNIT_CYC = (STAG_UNIT_NS + CLK_NS - 1) / CLK_NS;
  typedef struct packed {
    logic [16:0] cycle_len;
    logic [10:0] section_len;
    logic [9:0] sections;
    logic [5:0] scan_lines;
    logic gclk_mult_en;
  } ldgc_pwm_t;
  typedef struct packed {
    logic short_det_en;
    logic [1:0] global_gain_code;
    logic [2:0] adj_gain;
    logic [3:0] stagger_cyc;
  } ldgc_gain_t;
endpackage

// ### src/ldgc_top.sv
// Global configuration registers, serial command port and derived PWM settings
// Summary of operation
// - Depth field selects 65536 to 8192 cycle
// - Section field selects 1024 to 128 clocks
// - Scan lines equal field plus one
// - Bit 4 enables grayscale clock multiplier
// - Bits 3..0 reserved, reset zero
// - First register resets to 0060
// - Bit B enables resistor short detection
// - Constant gain code 01 or 11; logic passes any 2-bit code through unchecked
// - Adjustable gain 100 to 200 percent
// - Stagger delays 25, 50, 75 ns, rounded up to 3, 6, 9 clocks (30, 60, 90 ns)
// - Second register resets to 0E00
// - Write needs prior unlock command
// - Write loads last 32 bits, MSB first
// - Read shifts 48 bits out MSB first
// - Soft reset keeps configuration registers
module ldgc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_shift_clock,
  input wire logic latch_strobe,
  input wire logic serial_in,
  output logic serial_out,
  output logic [15:0] cfg1_out,
  output logic [15:0] cfg2_out,
  output ldgc_pkg::ldgc_pwm_t pwm_cfg,
  output ldgc_pkg::ldgc_gain_t gain_cfg,
  output logic soft_reset_cmd
);
  logic [1:0] sck_s_q, le_s_q, sdi_s_q;
  logic sck_prev_q, le_prev_q;
  logic [ldgc_pkg::FRAME_W-1:0] shift_q, shift_d;
  logic [ldgc_pkg::FRAME_W-1:0] out_q, out_d;
  logic [4:0] cnt_q, cnt_d;
  logic unlock_q, unlock_d;
  logic [15:0] cfg1_q, cfg1_d, cfg2_q, cfg2_d;
  logic sout_q, sout_d, soft_reset_cmd_q, soft_reset_cmd_d;
  ldgc_pkg::ldgc_pwm_t pwm_q, pwm_d;
  ldgc_pkg::ldgc_gain_t gain_q, gain_d;
  logic sck_rise, le_fall;

  // Two-flop synchronisers; only stage 2 is read by logic
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_s_q <= 2'h0;
      le_s_q <= 2'h0;
      sdi_s_q <= 2'h0;
      sck_prev_q <= 1'b0;
      le_prev_q <= 1'b0;
    end else begin
      sck_s_q <= {sck_s_q[0], serial_shift_clock};
      le_s_q <= {le_s_q[0], latch_strobe};
      sdi_s_q <= {sdi_s_q[0], serial_in};
      sck_prev_q <= sck_s_q[1];
      le_prev_q <= le_s_q[1];
    end
  end

  assign sck_rise = sck_s_q[1] & ~sck_prev_q;
  assign le_fall = ~le_s_q[1] & le_prev_q;

  always_comb begin
    shift_d = shift_q;
    out_d = out_q;
    cnt_d = cnt_q;
    unlock_d = unlock_q;
    cfg1_d = cfg1_q;
    cfg2_d = cfg2_q;
    sout_d = sout_q;
    soft_reset_cmd_d = 1'b0;
    if (sck_rise) begin
      shift_d = {shift_q[ldgc_pkg::FRAME_W-2:0], sdi_s_q[1]};
      out_d = {out_q[ldgc_pkg::FRAME_W-2:0], 1'b0};
      sout_d = out_q[ldgc_pkg::FRAME_W-1];
      if (le_s_q[1] && cnt_q != 5'h1F) begin
        cnt_d = cnt_q + 5'h01;
      end
    end
    if (le_fall) begin
      cnt_d = 5'h00;
      case (cnt_q)
        ldgc_pkg::CMD_UNLOCK: unlock_d = 1'b1;
        ldgc_pkg::CMD_WRITE: begin
          if (unlock_q) begin
            // Upper 16 bits are ignored; low 32 hold both registers, first register in bits 31..16
            cfg1_d = shift_q[31:16] & ldgc_pkg::CFG1_MASK;
            cfg2_d = shift_q[15:0];
          end
          unlock_d = 1'b0;
        end
        ldgc_pkg::CMD_READ: begin
          out_d = {16'h0000, cfg1_q, cfg2_q};
          unlock_d = 1'b0;
        end
        ldgc_pkg::CMD_SOFT_RESET_CMD: begin
          soft_reset_cmd_d = 1'b1;
          unlock_d = 1'b0;
        end
        default: unlock_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_q <= '0;
      out_q <= '0;
      cnt_q <= 5'h00;
      unlock_q <= 1'b0;
      cfg1_q <= ldgc_pkg::CFG1_RST;
      cfg2_q <= ldgc_pkg::CFG2_RST;
      sout_q <= 1'b0;
      soft_reset_cmd_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      out_q <= out_d;
      cnt_q <= cnt_d;
      unlock_q <= unlock_d;
      cfg1_q <= cfg1_d;
      cfg2_q <= cfg2_d;
      sout_q <= sout_d;
      soft_reset_cmd_q <= soft_reset_cmd_d;
    end
  end

  // Decoded settings; reserved bits deliberately unused
  always_comb begin
    logic [1:0] gs;
    logic [1:0] sp;
    logic [1:0] st;
    gs = cfg1_q[ldgc_pkg::GS_POS +: 2];
    sp = cfg1_q[ldgc_pkg::SP_POS +: 2];
    st = cfg2_q[ldgc_pkg::STAG_POS +: 2];
    pwm_d.cycle_len = 17'h10000 >> gs;
    pwm_d.section_len = 11'h400 >> sp;
    pwm_d.sections = 10'h040 >> gs << sp;
    pwm_d.scan_lines = {1'b0, cfg1_q[ldgc_pkg::SCAN_POS +: 5]} + 6'h01;
    pwm_d.gclk_mult_en = cfg1_q[ldgc_pkg::MULT_POS];
    gain_d.short_det_en = cfg2_q[ldgc_pkg::SHORT_POS];
    gain_d.global_gain_code = cfg2_q[ldgc_pkg::CG_POS +: 2];
    gain_d.adj_gain = cfg2_q[ldgc_pkg::AG_POS +: 3];
    gain_d.stagger_cyc = 4'(st * ldgc_pkg::STAG_UNIT_CYC);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_q <= '0;
      gain_q <= '0;
    end else begin
      pwm_q <= pwm_d;
      gain_q <= gain_d;
    end
  end

  assign serial_out = sout_q;
  assign cfg1_out = cfg1_q;
  assign cfg2_out = cfg2_q;
  assign pwm_cfg = pwm_q;
  assign gain_cfg = gain_q;
  assign soft_reset_cmd = soft_reset_cmd_q;

  // Reset is checked one edge on, so no history from before time zero is needed
  property p_reset_vals;
    @(posedge clk) rst |=> (cfg1_q == 16'h0060 && cfg2_q == 16'h0E00);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_locked_write;
    @(posedge clk) disable iff (rst) (le_fall && cnt_q == 5'h04 && !unlock_q) |=> $stable(cfg1_q) && $stable(cfg2_q);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("write without unlock");

  property p_write_load;
    @(posedge clk) disable iff (rst) (le_fall && cnt_q == 5'h04 && unlock_q) |=> cfg2_q == $past(shift_q[15:0]);
  endproperty
  a_write_load: assert property (p_write_load) else $error("write data not loaded");

  property p_write_load1;
    @(posedge clk) disable iff (rst) (le_fall && cnt_q == 5'h04 && unlock_q) |=> cfg1_q[13:0] == $past(shift_q[29:16]);
  endproperty
  a_write_load1: assert property (p_write_load1) else $error("first register not loaded");

  // Only a write may touch the registers; anything else leaves them alone
  property p_hold;
    @(posedge clk) disable iff (rst) !(le_fall && cnt_q == 5'h04) |=> $stable(cfg1_q) && $stable(cfg2_q);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without write");

  property p_cfg1_top;
    @(posedge clk) disable iff (rst) ##1 1'b1 |=> cfg1_q[15:14] == 2'h0;
  endproperty
  a_cfg1_top: assert property (p_cfg1_top) else $error("first register top bits set");

  property p_unlock_set;
    @(posedge clk) disable iff (rst) (le_fall && cnt_q == 5'h0E) |=> unlock_q;
  endproperty
  a_unlock_set: assert property (p_unlock_set) else $error("unlock not armed");

  property p_unlock_clr;
    @(posedge clk) disable iff (rst) (le_fall && cnt_q != 5'h0E) |=> !unlock_q;
  endproperty
  a_unlock_clr: assert property (p_unlock_clr) else $error("unlock not cleared");

  property p_cnt_clr;
    @(posedge clk) disable iff (rst) le_fall |=> cnt_q == 5'h00;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("edge count not cleared");

  property p_shift_in;
    @(posedge clk) disable iff (rst) sck_rise |=> shift_q[0] == $past(sdi_s_q[1]);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in");

  property p_no_shift;
    @(posedge clk) disable iff (rst) !sck_rise |=> $stable(shift_q);
  endproperty
  a_no_shift: assert property (p_no_shift) else $error("shift without clock edge");

  property p_shift_out;
    @(posedge clk) disable iff (rst) sck_rise |=> serial_out == $past(out_q[ldgc_pkg::FRAME_W-1]);
  endproperty
  a_shift_out: assert property (p_shift_out) else $error("serial output not msb first");

  property p_soft_reset_cmd_cmd;
    @(posedge clk) disable iff (rst) (le_fall && cnt_q == 5'h0A) |=> soft_reset_cmd_q;
  endproperty
  a_soft_reset_cmd_cmd: assert property (p_soft_reset_cmd_cmd) else $error("soft reset not issued");

  property p_soft_reset_cmd_pulse;
    @(posedge clk) disable iff (rst) soft_reset_cmd_q |=> !soft_reset_cmd_q;
  endproperty
  a_soft_reset_cmd_pulse: assert property (p_soft_reset_cmd_pulse) else $error("soft reset pulse too long");

  property p_soft_reset_cmd_keep;
    @(posedge clk) disable iff (rst) soft_reset_cmd_q |-> $stable(cfg1_q) && $stable(cfg2_q);
  endproperty
  a_soft_reset_cmd_keep: assert property (p_soft_reset_cmd_keep) else $error("soft reset altered config");

  // Decoded settings trail the registers by exactly one clock
  property p_cycle;
    @(posedge clk) disable iff (rst) ##1 1'b1 |=> pwm_cfg.cycle_len == (17'h10000 >> $past(cfg1_q[13:12]));
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle length wrong");

  property p_section;
    @(posedge clk) disable iff (rst) ##1 1'b1 |=> pwm_cfg.section_len == (11'h400 >> $past(cfg1_q[11:10]));
  endproperty
  a_section: assert property (p_section) else $error("section length wrong");

  // Sections times section length must rebuild the whole cycle
  property p_sections;
    @(posedge clk) disable iff (rst) ##1 1'b1 |=> (pwm_cfg.sections * pwm_cfg.section_len) == pwm_cfg.cycle_len;
  endproperty
  a_sections: assert property (p_sections) else $error("section count wrong");

  property p_scan;
    @(posedge clk) disable iff (rst) ##1 1'b1 |=> pwm_cfg.scan_lines == $past(cfg1_q[9:5]) + 6'h01;
  endproperty
  a_scan: assert property (p_scan) else $error("scan lines wrong");

  property p_read_first;
    @(posedge clk) disable iff (rst) (le_fall && cnt_q == 5'h05) |=> out_q == {16'h0000, $past(cfg1_q), $past(cfg2_q)};
  endproperty
  a_read_first: assert property (p_read_first) else $error("read frame not loaded");

  property p_mult;
    @(posedge clk) disable iff (rst) ##1 1'b1 |=> pwm_cfg.gclk_mult_en == $past(cfg1_q[4]) && gain_cfg.short_det_en == $past(cfg2_q[11]);
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier or short enable wrong");

  property p_gain_code;
    @(posedge clk) disable iff (rst) ##1 1'b1 |=> gain_cfg.global_gain_code == $past(cfg2_q[10:9]);
  endproperty
  a_gain_code: assert property (p_gain_code) else $error("constant gain code wrong");

  property p_adj_gain;
    @(posedge clk) disable iff (rst) ##1 1'b1 |=> gain_cfg.adj_gain == $past(cfg2_q[8:6]);
  endproperty
  a_adj_gain: assert property (p_adj_gain) else $error("adjustable gain wrong");

  // Stagger rounds up to whole clocks, so it never undershoots the delay
  property p_stagger;
    @(posedge clk) disable iff (rst) ##1 1'b1 |=> gain_cfg.stagger_cyc == 4'($past(cfg2_q[4:3]) * ldgc_pkg::STAG_UNIT_CYC);
  endproperty
  a_stagger: assert property (p_stagger) else $error("stagger delay wrong");
endmodule // ldgc_top

// ### test/ldgc_ctrl_model.sv
// Display controller model driving the serial command link
module ldgc_ctrl_model (
  input wire logic clk,
  input wire logic serial_out,
  output logic serial_shift_clock,
  output logic latch_strobe,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [47:0] rd_q;
  initial begin
    serial_shift_clock = 1'b0;
    latch_strobe = 1'b0;
    serial_in = 1'b0;
  end
  // Phases of 4 clk stay clear of the two-flop pin synchroniser
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic xfer(input logic [47:0] d, input int nb, input int nle);
    for (int i = nb - 1; i >= 0; i--) begin
      serial_in = d[i];
      latch_strobe = (i < nle);
      step(4);
      serial_shift_clock = 1'b1;
      step(4);
      serial_shift_clock = 1'b0;
      step(3);
      rd_q = {rd_q[46:0], serial_out};
    end
    latch_strobe = 1'b0;
    // Released line shows the inverse, never a stale bit
    serial_in = ~serial_in;
    step(8);
  endtask
  task automatic cfg_write(input logic [31:0] v, input bit unlock);
    if (unlock) xfer(48'h0, 14, 14);
    xfer({16'hA5A5, v}, 48, 4);
  endtask
  task automatic cfg_read();
    xfer(48'h0, 5, 5);
    xfer(48'h0, 48, 0);
  endtask
endmodule // ldgc_ctrl_model

// ### test/tb_ldgc_top.sv
// Testbench for the global configuration block
module tb_ldgc_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [15:0] c1; logic [15:0] c2; logic [16:0] cyc; logic [9:0] secs;} ldgc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic serial_shift_clock, latch_strobe, serial_in, serial_out, soft_reset_cmd;
  logic [15:0] cfg1_out, cfg2_out;
  ldgc_pkg::ldgc_pwm_t pwm_cfg;
  ldgc_pkg::ldgc_gain_t gain_cfg;
  int fails = 0;
  int samples_checked = 0;
  int pulses = 0;
  ldgc_row_t rows [4] = '{'{16'h0000, 16'h0200, 17'h10000, 10'h040}, '{16'h14A0, 16'h0E50, 17'h08000, 10'h040},
    '{16'h2FFF, 16'hFFFF, 17'h04000, 10'h080}, '{16'h3865, 16'h0A08, 17'h02000, 10'h020}};
  always #5 clk = ~clk;
  always @(posedge clk) if (soft_reset_cmd === 1'b1) pulses++;
  ldgc_top i_ldgc_top (.clk(clk), .rst(rst), .serial_shift_clock(serial_shift_clock), .latch_strobe(latch_strobe),
    .serial_in(serial_in), .serial_out(serial_out), .cfg1_out(cfg1_out), .cfg2_out(cfg2_out), .pwm_cfg(pwm_cfg),
    .gain_cfg(gain_cfg), .soft_reset_cmd(soft_reset_cmd));
  ldgc_ctrl_model i_ldgc_ctrl_model (.clk(clk), .serial_out(serial_out), .serial_shift_clock(serial_shift_clock),
    .latch_strobe(latch_strobe), .serial_in(serial_in));
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk(input ldgc_row_t r);
    cmp(cfg1_out, r.c1 & ldgc_pkg::CFG1_MASK, "cfg1");
    cmp(cfg2_out, r.c2, "cfg2");
    cmp(pwm_cfg.cycle_len, r.cyc, "cycle");
    cmp(pwm_cfg.section_len, 32'h400 >> r.c1[11:10], "section");
    cmp(pwm_cfg.sections, r.secs, "sections");
    cmp(pwm_cfg.scan_lines, {1'b0, r.c1[9:5]} + 6'h01, "scan");
    cmp(pwm_cfg.gclk_mult_en, r.c1[4], "mult");
    cmp(gain_cfg, {r.c2[11:6], 4'(r.c2[4:3] * ldgc_pkg::STAG_UNIT_CYC)}, "gain");
    i_ldgc_ctrl_model.cfg_read();
    cmp(i_ldgc_ctrl_model.rd_q, {16'h0000, r.c1 & ldgc_pkg::CFG1_MASK, r.c2}, "read");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    i_ldgc_ctrl_model.step(12);
    rst = 1'b0;
    foreach (rows[i]) begin
      i_ldgc_ctrl_model.cfg_write({rows[i].c1, rows[i].c2}, 1'b1);
      chk(rows[i]);
      $display("row %0d done", i);
    end
    // An intervening read cancels the unlock
    i_ldgc_ctrl_model.xfer(48'h0, 14, 14);
    i_ldgc_ctrl_model.cfg_read();
    i_ldgc_ctrl_model.cfg_write(32'h0, 1'b0);
    chk(rows[3]);
    i_ldgc_ctrl_model.xfer(48'h0, 10, 10);
    cmp(pulses, 1, "soft reset pulse");
    chk(rows[3]);
    $display("refusal and soft reset done");
    rst = 1'b1;
    i_ldgc_ctrl_model.step(12);
    rst = 1'b0;
    i_ldgc_ctrl_model.step(2);
    chk('{16'h0060, 16'h0E00, 17'h10000, 10'h040});
    $display("reset defaults done");
    tally_and_finish();
  end
  initial begin
    #500us;
    fails++;
    tally_and_finish();
  end
endmodule // tb_ldgc_top
